// >>> shared/swr_pkg.sv
// Package: constants and types for the supervisor watchdog restart block
package swr_pkg;

   // Command code of the watchdog setup register
   localparam logic [7:0] SWR_SETUP_CMD    = 8'hee;
   // Setup field layout: bit 7 enable, bits 3:0 timeout select
   localparam int         SWR_EN_BIT       = 7;
   localparam int         SWR_SEL_LSB      = 0;
   localparam int         SWR_SEL_W        = 4;
   // Value after reset and in blank nonvolatile memory: enabled, longest
   localparam logic [7:0] SWR_SETUP_RST    = 8'h8f;
   // Base timeout unit in microseconds, and in 50 ns cycles
   localparam int         SWR_CLK_NS       = 50;
   localparam int         SWR_UNIT_US      = 1000;
   localparam int         SWR_UNIT_CYC     = (SWR_UNIT_US * 1000) / SWR_CLK_NS;
   // Broadcast message: distinct code for watchdog restart
   localparam logic [7:0] SWR_MSG_RESTART  = 8'ha5;
   localparam int         SWR_MSG_BITS     = 8;
   // Half period of the link bit clock in mclk cycles
   localparam int         SWR_HALF_CYC     = 25;
   // Restart pulse length in cycles
   localparam int         SWR_RST_CYC      = 16;

   // Link transmitter states
   typedef enum logic [1:0] {
      SWR_TX_IDLE  = 2'b00,
      SWR_TX_START = 2'b01,
      SWR_TX_BITS  = 2'b10,
      SWR_TX_STOP  = 2'b11
   } swr_tx_t;

endpackage : swr_pkg

// >>> design/swr_link_rx.sv
// Receiver of restart broadcasts on the interdevice link
`timescale 1ns/1ps
`default_nettype none
module swr_link_rx (
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       rst,
   // Link pins, raw
   input  wire logic       clk_pin_in,
   input  wire logic       data_pin_in,
   // Decoded restart broadcast, one cycle
   output logic            restart_heard
);

   logic [2:0] clk_sync_reg;
   logic [2:0] dat_sync_reg;
   logic       clk_q_reg;
   logic       dat_q_reg;
   logic       busy_reg;
   logic [3:0] cnt_reg;
   logic [7:0] shift_reg;

   ////////////////////////////////////////////////////////////////////
   // Three-stage pin synchronisers; level accepted on agreement
   always_ff @(posedge mclk) begin
      if (rst) begin
         clk_sync_reg <= 3'h7;
         dat_sync_reg <= 3'h7;
         clk_q_reg    <= 1'b1;
         dat_q_reg    <= 1'b1;
      end else begin
         clk_sync_reg <= {clk_sync_reg[1:0], clk_pin_in};
         dat_sync_reg <= {dat_sync_reg[1:0], data_pin_in};
         if (clk_sync_reg[1] == clk_sync_reg[2])
            clk_q_reg <= clk_sync_reg[2];
         if (dat_sync_reg[1] == dat_sync_reg[2])
            dat_q_reg <= dat_sync_reg[2];
      end
   end

   wire logic clk_f = clk_sync_reg[1] == clk_sync_reg[2] ?
                      clk_sync_reg[2] : clk_q_reg;
   wire logic dat_f = dat_sync_reg[1] == dat_sync_reg[2] ?
                      dat_sync_reg[2] : dat_q_reg;

   ////////////////////////////////////////////////////////////////////
   // Start is data falling while clock high; bits taken on clock rise
   always_ff @(posedge mclk) begin
      if (rst) begin
         busy_reg      <= 1'b0;
         cnt_reg       <= 4'h0;
         shift_reg     <= 8'h00;
         restart_heard <= 1'b0;
      end else begin
         restart_heard <= 1'b0;
         if (!busy_reg && clk_f && clk_q_reg && dat_q_reg && !dat_f) begin
            busy_reg <= 1'b1;
            cnt_reg  <= 4'h0;
         end else if (busy_reg && clk_f && !clk_q_reg) begin
            shift_reg <= {shift_reg[6:0], dat_f};
            cnt_reg   <= cnt_reg + 4'h1;
            if (cnt_reg == 4'(swr_pkg::SWR_MSG_BITS - 1)) begin
               busy_reg <= 1'b0;
               // Only the distinct restart code restarts us
               restart_heard <= {shift_reg[6:0], dat_f} ==
                                swr_pkg::SWR_MSG_RESTART;
            end
         end
      end
   end

endmodule : swr_link_rx
`default_nettype wire

// >>> design/swr_watchdog.sv
// Watchdog with setup register, restart output and link broadcast
`timescale 1ns/1ps
`default_nettype none
module swr_watchdog #(
   parameter int UNIT_CYC = swr_pkg::SWR_UNIT_CYC
) (
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       rst,
   // Management command port, byte wide
   input  wire logic       cmd_wr,
   input  wire logic       cmd_rd,
   input  wire logic [7:0] cmd_code,
   input  wire logic [7:0] cmd_wdata,
   output logic     [7:0]  cmd_rdata,
   output logic            cmd_ack,
   // Save to nonvolatile memory, and the value stored there
   input  wire logic       store_req,
   input  wire logic [7:0] nv_setup_in,
   output logic     [7:0]  nv_setup_out,
   output logic            nv_store,
   // Controller service strobe
   input  wire logic       service,
   // Restart to the device and alert pin (never driven by us)
   output logic            restart_out,
   output logic            alert_low_oe,
   // Interdevice link pins
   input  wire logic       interdevice_clock_pin_in,
   output logic            interdevice_clock_pin_out,
   output logic            interdevice_clock_pin_oe,
   input  wire logic       interdevice_data_pin_in,
   output logic            interdevice_data_pin_out,
   output logic            interdevice_data_pin_oe
);

   logic [7:0]      watchdog_setup_reg;
   logic [7:0]      active_setup_reg;
   logic            loaded_reg;
   logic [31:0]     unit_cnt_reg;
   logic [15:0]     units_reg;
   logic            fire;
   logic            heard;
   logic [4:0]      rst_cnt_reg;
   swr_pkg::swr_tx_t tx_state_reg;
   logic [5:0]      half_reg;
   logic [3:0]      bit_reg;
   logic            phase_reg;

   wire logic       en = active_setup_reg[swr_pkg::SWR_EN_BIT];
   wire logic [3:0] sel =
      active_setup_reg[swr_pkg::SWR_SEL_LSB +: swr_pkg::SWR_SEL_W];
   // Timeout is 2^sel units: wide range with a four-bit field
   wire logic [15:0] limit = 16'h0001 << sel;

   ////////////////////////////////////////////////////////////////////
   // Stored setup is taken once after power up; register writes only
   // matter once saved and cycled, so the active copy is not rewritten
   always_ff @(posedge mclk) begin
      if (rst) begin
         active_setup_reg <= swr_pkg::SWR_SETUP_RST;
         loaded_reg       <= 1'b0;
      end else if (!loaded_reg) begin
         active_setup_reg <= nv_setup_in;
         loaded_reg       <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Setup register access and save
   always_ff @(posedge mclk) begin
      if (rst) begin
         watchdog_setup_reg <= swr_pkg::SWR_SETUP_RST;
         cmd_rdata          <= 8'h00;
         cmd_ack            <= 1'b0;
         nv_setup_out       <= swr_pkg::SWR_SETUP_RST;
         nv_store           <= 1'b0;
      end else begin
         cmd_ack  <= (cmd_wr | cmd_rd) && cmd_code == swr_pkg::SWR_SETUP_CMD;
         nv_store <= store_req;
         if (!loaded_reg)
            watchdog_setup_reg <= nv_setup_in;
         else if (cmd_wr && cmd_code == swr_pkg::SWR_SETUP_CMD)
            watchdog_setup_reg <= cmd_wdata;
         if (cmd_rd && cmd_code == swr_pkg::SWR_SETUP_CMD)
            cmd_rdata <= watchdog_setup_reg;
         else if (cmd_rd)
            cmd_rdata <= 8'h00;
         if (store_req)
            nv_setup_out <= watchdog_setup_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Timeout counter, cleared by service
   always_ff @(posedge mclk) begin
      if (rst || restart_out || service || !en || !loaded_reg) begin
         unit_cnt_reg <= 32'h0;
         units_reg    <= 16'h0;
      end else if (unit_cnt_reg == 32'(UNIT_CYC - 1)) begin
         unit_cnt_reg <= 32'h0;
         units_reg    <= units_reg + 16'h1;
      end else begin
         unit_cnt_reg <= unit_cnt_reg + 32'h1;
      end
   end

   assign fire = en && loaded_reg && !restart_out && !service &&
                 units_reg == limit;

   swr_link_rx u_rx (
      .mclk          (mclk),
      .rst           (rst),
      .clk_pin_in    (interdevice_clock_pin_in),
      .data_pin_in   (interdevice_data_pin_in),
      .restart_heard (heard)
   );

   ////////////////////////////////////////////////////////////////////
   // Restart pulse, from own timeout or peer broadcast
   always_ff @(posedge mclk) begin
      if (rst) begin
         restart_out  <= 1'b0;
         rst_cnt_reg  <= 5'h0;
         alert_low_oe <= 1'b0;
      end else begin
         alert_low_oe <= 1'b0;
         // Our own broadcast echoes back through the receiver; it is
         // ignored while we transmit, so only peers obey it
         if (fire || (heard && !restart_out &&
                      tx_state_reg == swr_pkg::SWR_TX_IDLE)) begin
            restart_out <= 1'b1;
            rst_cnt_reg <= 5'(swr_pkg::SWR_RST_CYC - 1);
         end else if (rst_cnt_reg != 5'h0) begin
            rst_cnt_reg <= rst_cnt_reg - 5'h1;
         end else begin
            restart_out <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Broadcast transmitter: start, eight bits MSB first, stop.
   // Open drain: drives only low, so out is tied low when enabled.
   always_ff @(posedge mclk) begin
      if (rst) begin
         tx_state_reg              <= swr_pkg::SWR_TX_IDLE;
         half_reg                  <= 6'h0;
         bit_reg                   <= 4'h0;
         phase_reg                 <= 1'b0;
         interdevice_clock_pin_out <= 1'b0;
         interdevice_clock_pin_oe  <= 1'b0;
         interdevice_data_pin_out  <= 1'b0;
         interdevice_data_pin_oe   <= 1'b0;
      end else begin
         case (tx_state_reg)
            swr_pkg::SWR_TX_IDLE: begin
               interdevice_clock_pin_oe <= 1'b0;
               interdevice_data_pin_oe  <= 1'b0;
               if (fire) begin
                  tx_state_reg            <= swr_pkg::SWR_TX_START;
                  interdevice_data_pin_oe <= 1'b1;
                  half_reg                <= 6'h0;
               end
            end
            swr_pkg::SWR_TX_START: begin
               if (half_reg == 6'(swr_pkg::SWR_HALF_CYC - 1)) begin
                  half_reg                 <= 6'h0;
                  interdevice_clock_pin_oe <= 1'b1;
                  tx_state_reg             <= swr_pkg::SWR_TX_BITS;
                  bit_reg                  <= 4'h0;
                  phase_reg                <= 1'b0;
               end else
                  half_reg <= half_reg + 6'h1;
            end
            swr_pkg::SWR_TX_BITS: begin
               // Data moves mid-way through clock low, never with a clock
               // edge, so a peer cannot see it change under a high clock
               if (!phase_reg && half_reg == 6'(swr_pkg::SWR_HALF_CYC / 2))
                  interdevice_data_pin_oe <=
                     !swr_pkg::SWR_MSG_RESTART[3'(7 - bit_reg)];
               if (half_reg == 6'(swr_pkg::SWR_HALF_CYC - 1)) begin
                  half_reg  <= 6'h0;
                  phase_reg <= !phase_reg;
                  if (!phase_reg) begin
                     // Release clock; the bit is read on its rise
                     interdevice_clock_pin_oe <= 1'b0;
                  end else begin
                     interdevice_clock_pin_oe <= 1'b1;
                     bit_reg                  <= bit_reg + 4'h1;
                     if (bit_reg == 4'(swr_pkg::SWR_MSG_BITS - 1))
                        tx_state_reg <= swr_pkg::SWR_TX_STOP;
                  end
               end else
                  half_reg <= half_reg + 6'h1;
            end
            swr_pkg::SWR_TX_STOP: begin
               // Pull data low mid-way through the last clock low
               if (interdevice_clock_pin_oe &&
                   half_reg == 6'(swr_pkg::SWR_HALF_CYC / 2))
                  interdevice_data_pin_oe <= 1'b1;
               if (half_reg == 6'(swr_pkg::SWR_HALF_CYC - 1)) begin
                  half_reg <= 6'h0;
                  if (interdevice_clock_pin_oe)
                     interdevice_clock_pin_oe <= 1'b0;
                  else begin
                     interdevice_data_pin_oe <= 1'b0;
                     tx_state_reg <= swr_pkg::SWR_TX_IDLE;
                  end
               end else
                  half_reg <= half_reg + 6'h1;
            end
            default: tx_state_reg <= swr_pkg::SWR_TX_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_fire;
      fire;
   endsequence

   // Own timeout while the transmitter is free to send
   sequence s_fire_free;
      s_fire and (tx_state_reg == swr_pkg::SWR_TX_IDLE);
   endsequence

   a_fire_restart: assert property (@(posedge mclk) disable iff (rst)
      s_fire |=> restart_out) else $error("no restart");
   a_setup_write: assert property (@(posedge mclk) disable iff (rst)
      cmd_wr && cmd_code == swr_pkg::SWR_SETUP_CMD && loaded_reg
      |=> watchdog_setup_reg == $past(cmd_wdata))
      else $error("setup write lost");
   a_write_no_effect: assert property (@(posedge mclk) disable iff (rst)
      loaded_reg |=> $stable(active_setup_reg))
      else $error("active setup changed");
   a_fire_broadcast: assert property (@(posedge mclk) disable iff (rst)
      s_fire_free |=> interdevice_data_pin_oe) else $error("no broadcast");
   a_peer_restart: assert property (@(posedge mclk) disable iff (rst)
      heard && !restart_out && tx_state_reg == swr_pkg::SWR_TX_IDLE
      |=> restart_out) else $error("peer ignored");
   a_alert_quiet: assert property (@(posedge mclk) disable iff (rst)
      restart_out |-> !alert_low_oe) else $error("alert driven");
   a_default_on: assert property (@(posedge mclk)
      !rst && $past(rst) |-> active_setup_reg == swr_pkg::SWR_SETUP_RST)
      else $error("not enabled at reset");
   a_service_clear: assert property (@(posedge mclk) disable iff (rst)
      service |=> units_reg == 16'h0 && unit_cnt_reg == 32'h0)
      else $error("service ignored");

endmodule : swr_watchdog
`default_nettype wire

// >>> testbench/swr_peer_model.sv
// Peer sequencer model on the interdevice link
`timescale 1ns/1ps
`default_nettype none
module swr_peer_model (
   // Clock
   input  wire logic       mclk,
   // Resolved link wires, pulled up
   input  wire logic       clk_wire,
   input  wire logic       data_wire,
   // Open drain pulls, high pulls the wire low
   output logic            clk_oe,
   output logic            data_oe,
   // Last byte decoded and count of bytes decoded
   output logic     [7:0]  rx_byte,
   output logic     [7:0]  rx_cnt
);
   logic       prev_clk;
   logic       prev_data;
   logic       busy;
   logic [3:0] nbit;
   logic [7:0] rx_sh;
   ////////////////////////////////////////////////////////////////////////
   // Idle: both lines released to the pull-up
   initial begin
      clk_oe = 1'b0;
      data_oe = 1'b0;
      rx_byte = 8'h00;
      rx_cnt = 8'h00;
      busy = 1'b0;
   end
   // One half bit of link time
   task automatic half();
      repeat (swr_pkg::SWR_HALF_CYC) @(posedge mclk);
   endtask : half
   // Byte frame, MSB first; clock only toggles inside the frame
   task automatic send(input logic [7:0] code);
      data_oe <= 1'b1;
      half();
      for (int i = 7; i >= 0; i--) begin
         clk_oe  <= 1'b1;
         data_oe <= ~code[i];
         half();
         clk_oe <= 1'b0;
         half();
      end
      clk_oe  <= 1'b1;
      data_oe <= 1'b1;
      half();
      clk_oe <= 1'b0;
      half();
      data_oe <= 1'b0;
      half();
   endtask : send
   ////////////////////////////////////////////////////////////////////////
   // Decoder: start is data falling under a high clock
   always @(posedge mclk) begin
      if (clk_wire && prev_data && !data_wire) begin
         busy <= 1'b1;
         nbit <= 4'h0;
      end else if (busy && clk_wire && !prev_clk) begin
         // Shift privately; a cut frame never disturbs the last byte
         rx_sh <= {rx_sh[6:0], data_wire};
         nbit  <= nbit + 4'h1;
         if (nbit == 4'h7) begin
            busy    <= 1'b0;
            rx_byte <= {rx_sh[6:0], data_wire};
            rx_cnt  <= rx_cnt + 8'h01;
         end
      end
      prev_clk  <= clk_wire;
      prev_data <= data_wire;
   end
endmodule : swr_peer_model
`default_nettype wire

// >>> testbench/supervisor_watchdog_restart_bench.sv
// Self-checking bench for the watchdog with a peer on the link
`timescale 1ns/1ps
`default_nettype none
module supervisor_watchdog_restart_bench;
   typedef struct packed {logic [7:0] setup; logic kick; logic fires;} swr_row_t;
   localparam int UNIT = 4;
   // Stimulus
   logic       mclk = 1'b0, rst = 1'b1, cmd_wr = 1'b0, cmd_rd = 1'b0;
   logic       store_req = 1'b0, service = 1'b0;
   logic [7:0] cmd_code = 8'h00, cmd_wdata = 8'h00, nv_setup_in = 8'h8f;
   // Observed
   logic [7:0] cmd_rdata, nv_setup_out, rx_byte, rx_cnt, cnt0;
   logic       cmd_ack, nv_store, restart_out, alert_low_oe, nc_c, nc_d;
   logic       dut_clk_oe, dut_data_oe, peer_clk_oe, peer_data_oe;
   wire logic  clk_wire;
   wire logic  data_wire;
   int         error_cnt = 0, total_checks = 0, cyc = 0, first, run, lim;
   swr_row_t   rows [4];
   ////////////////////////////////////////////////////////////////////////
   // Clock and open-drain wires with pull-ups
   always #25 mclk = ~mclk;
   assign clk_wire  = ~(dut_clk_oe | peer_clk_oe);
   assign data_wire = ~(dut_data_oe | peer_data_oe);
   swr_watchdog #(.UNIT_CYC(UNIT)) DUT (.mclk(mclk), .rst(rst),
      .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code),
      .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_ack(cmd_ack),
      .store_req(store_req), .nv_setup_in(nv_setup_in),
      .nv_setup_out(nv_setup_out), .nv_store(nv_store), .service(service),
      .restart_out(restart_out), .alert_low_oe(alert_low_oe),
      .interdevice_clock_pin_in(clk_wire), .interdevice_clock_pin_out(nc_c),
      .interdevice_clock_pin_oe(dut_clk_oe),
      .interdevice_data_pin_in(data_wire), .interdevice_data_pin_out(nc_d),
      .interdevice_data_pin_oe(dut_data_oe));
   swr_peer_model peer (.mclk(mclk), .clk_wire(clk_wire),
      .data_wire(data_wire), .clk_oe(peer_clk_oe), .data_oe(peer_data_oe),
      .rx_byte(rx_byte), .rx_cnt(rx_cnt));
   ////////////////////////////////////////////////////////////////////////
   // Hang guard, well above the few thousand cycles the run needs
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         error_cnt++;
         test_done();
      end
   end
   task automatic chk(input string name, input logic [7:0] exp, got);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   // Power cycle with a given stored setup; ready two edges after release
   task automatic power(input logic [7:0] nv);
      nv_setup_in <= nv;
      rst <= 1'b1;
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      repeat (2) @(posedge mclk);
   endtask : power
   // Watch n cycles: first restart cycle and its unbroken length
   task automatic watch(input logic kick, input int n);
      first = -1;
      run = 0;
      for (int i = 0; i < n; i++) begin
         @(posedge mclk);
         service <= kick && (i % 8 == 0);
         #1;
         if (restart_out === 1'b1) begin
            if (first < 0) first = i + 1;
            if (first + run == i + 1) run++;
         end
      end
   endtask : watch
   task automatic cmd(input logic wr, input logic [7:0] code, data);
      @(posedge mclk);
      cmd_wr <= wr;
      cmd_rd <= ~wr;
      cmd_code <= code;
      cmd_wdata <= data;
      @(posedge mclk);
      cmd_wr <= 1'b0;
      cmd_rd <= 1'b0;
      #1;
   endtask : cmd
   task automatic test_done();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : test_done
   ////////////////////////////////////////////////////////////////////////
   // Rows: stored setup, service on, restart expected
   initial begin
      rows[0] = '{8'h80, 1'b0, 1'b1};
      rows[1] = '{8'h83, 1'b0, 1'b1};
      rows[2] = '{8'h82, 1'b1, 1'b0};
      rows[3] = '{8'h00, 1'b0, 1'b0};
      foreach (rows[r]) begin
         cnt0 = rx_cnt;
         power(rows[r].setup);
         watch(rows[r].kick, 100);
         lim = UNIT << rows[r].setup[3:0];
         chk("fired", {7'h0, rows[r].fires}, {7'h0, first >= 0});
         if (rows[r].fires) begin
            chk("on_time", 8'h01, {7'h0, first >= lim - 2 && first <= lim + 3});
            chk("pulse", 8'(swr_pkg::SWR_RST_CYC), 8'(run));
            repeat (600) @(posedge mclk);
            chk("bcast", swr_pkg::SWR_MSG_RESTART, rx_byte);
            chk("bcast_cnt", 8'h01, rx_cnt - cnt0);
         end
         chk("alert", 8'h00, {7'h0, alert_low_oe});
         chk("od_low", 8'h00, {6'h0, nc_c, nc_d});
      end
      // Peer broadcasts: a foreign code is ignored, the restart code obeyed
      power(8'h00);
      fork
         peer.send(8'h5a);
         watch(1'b0, 500);
      join
      chk("foreign", 8'h00, {7'h0, first >= 0});
      fork
         peer.send(swr_pkg::SWR_MSG_RESTART);
         watch(1'b0, 500);
      join
      chk("peer_rst", 8'h01, {7'h0, first >= 404 && first <= 407});
      chk("peer_len", 8'(swr_pkg::SWR_RST_CYC), 8'(run));
      // Reset values, setup access, foreign codes, save and power cycle
      power(8'h8f);
      chk("rst_nv", 8'h8f, nv_setup_out);
      chk("rst_out", 8'h00, {7'h0, restart_out});
      cmd(1'b1, swr_pkg::SWR_SETUP_CMD, 8'h81);
      chk("ack", 8'h01, {7'h0, cmd_ack});
      cmd(1'b0, swr_pkg::SWR_SETUP_CMD, 8'h00);
      chk("rdata", 8'h81, cmd_rdata);
      cmd(1'b1, 8'h10, 8'h00);
      chk("no_ack", 8'h00, {7'h0, cmd_ack});
      cmd(1'b0, 8'h10, 8'h00);
      chk("other_rd", 8'h00, cmd_rdata);
      @(posedge mclk);
      store_req <= 1'b1;
      @(posedge mclk);
      store_req <= 1'b0;
      #1;
      chk("store", 8'h01, {7'h0, nv_store});
      chk("saved", 8'h81, nv_setup_out);
      // Not active until the next power cycle
      watch(1'b0, 40);
      chk("not_yet", 8'h00, {7'h0, first >= 0});
      power(nv_setup_out);
      watch(1'b0, 40);
      chk("applied", 8'h01, {7'h0, first >= 6 && first <= 11});
      test_done();
   end
endmodule : supervisor_watchdog_restart_bench
`default_nettype wire
